// ---- atatf_regs.sv ----
// Purpose: Task-file drive/head, status, command, device control and readback.
// Assumes: Host port is synchronous to ref_clk; core events come from same clock.
// Notes: One byte register port with read and write strobes.
// Notes on behaviour
// [RULE_01] Head register bit 6 picks CHS or LBA
// [RULE_02] LBA built from sector, cylinders, head bits
// [RULE_03] Host writes ones to bits 7 and 5
// [RULE_04] Respond only when unit bit matches card
// [RULE_05] Low four head bits hold head number
// [RULE_06] Primary status read negates level interrupt
// [RULE_07] Status byte layout; index reads zero
// [RULE_08] Media commands need ready and seek done
// [RULE_09] Transfer request set ready, cleared by command
// [RULE_10] Repaired and write fault flags from core
// [RULE_11] Error flag set on failure, cleared next command
// [RULE_12] Alternate status never negates interrupt
// [RULE_13] Host loads parameters then writes command
// [RULE_14] Decode single-sector read and write codes
// [RULE_15] Decode multiple read, write, set size
// [RULE_16] Count zero means 256 sectors
// [RULE_17] Soft reset bit holds task-file reset
// [RULE_18] Interrupt disable bit gates interrupt output
// [RULE_19] Host sets bit 3, clears bit 0
// [RULE_20] Readback: bit7 undriven, inverted head, unit lows
// [RULE_21] Identify reports geometry and id strings
// [RULE_22] Identify capabilities word reports LBA only; code sends 0a00, which also sets bit 11
// [RULE_23] Identify reports one sector per block
// [RULE_24] Aborted commands set error abort bit
// [RULE_25] Writes ignored while busy except control
`timescale 1ns/1ps
`default_nettype none
module atatf_regs
  import atatf_pkg::*;
#(
  parameter logic [15:0] SERIAL_WORD = 16'h5331, // Arbitrary value, stands in for an id string.
  parameter logic [15:0] FIRMWARE_WORD = 16'h5631, // Arbitrary value.
  parameter logic [15:0] MODEL_WORD = 16'h4d31 // Arbitrary value.
) (
  input wire logic ref_clk, // 50 MHz clock
  input wire logic reset_n, // Async active-low reset
  input wire logic [3:0] reg_addr, // Register offset
  input wire logic reg_rd, // Read strobe, one cycle
  input wire logic reg_wr, // Write strobe, one cycle
  input wire logic reg_ctl_sel, // Write at 0xe goes to device control
  input wire logic [7:0] reg_wdata, // Write data
  output logic [7:0] reg_rdata, // Read data, registered
  output logic reg_rdata_oe, // Read data drive enable per bit 0..6
  output logic reg_bit7_oe, // Drive enable of read bit 7
  input wire logic [1:0] card_index, // Configuration index
  input wire logic level_irq_mode, // Level interrupt mode
  input wire logic card_number, // Card number from socket config
  input wire logic core_ready, // Core ready level
  input wire logic core_seek_done, // Core seek done level
  input wire logic core_done, // Command finished pulse
  input wire logic core_fail, // Command failed pulse
  input wire logic [7:0] core_err_code, // Error detail on fail
  input wire logic core_xfer_ready, // Data may move pulse
  input wire logic core_xfer_end, // Data phase end pulse
  input wire logic core_repaired, // Corrected error pulse
  input wire logic core_write_fault, // Write fault level
  input wire logic core_irq, // Interrupt event pulse
  input wire logic [7:0] id_addr, // Identify word address
  output logic [15:0] id_data, // Identify word, registered
  output atatf_pkg::atatf_cmd_t cmd_out, // Accepted command, registered
  output logic [7:0] multiple_size, // Multiple block size
  output logic task_reset, // Task file reset level
  output logic interrupt_request_n // Active-low interrupt
);
  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  logic rst_s1_q;
  logic rst_n_q;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  logic [7:0] head_and_addressing_select_q;
  logic [7:0] count_q;
  logic [7:0] sector_q;
  logic [7:0] cyl_lo_q;
  logic [7:0] cyl_hi_q;
  logic [7:0] error_q;
  logic soft_reset_bit_q;
  logic interrupt_disable_bit_q;
  logic busy_flag_q;
  logic transfer_request_flag_q;
  logic repaired_data_flag_q;
  logic error_flag_q;
  logic irq_pend_q;
  logic selected;
  logic wr_ok;
  logic wr_ctl;
  logic cmd_wr;
  logic media_cmd;
  logic known_cmd;
  logic cmd_ok;
  atatf_status_t status;

  function automatic logic is_media(input logic [7:0] c);
    is_media = (c == ATATF_CMD_READ0) || (c == ATATF_CMD_READ1) || (c == ATATF_CMD_WRITE0) ||
      (c == ATATF_CMD_WRITE1) || (c == ATATF_CMD_WRITE_NE) || (c == ATATF_CMD_READ_MULT) ||
      (c == ATATF_CMD_WRITE_MULT) || (c[7:4] == ATATF_CMD_SEEK_HI[7:4]);
  endfunction : is_media

  function automatic atatf_kind_t kind_of(input logic [7:0] c);
    if ((c == ATATF_CMD_READ0) || (c == ATATF_CMD_READ1) || (c == ATATF_CMD_READ_MULT) ||
        (c == ATATF_CMD_IDENTIFY)) begin
      kind_of = ATATF_KIND_READ;
    end else if ((c == ATATF_CMD_WRITE0) || (c == ATATF_CMD_WRITE1) ||
                 (c == ATATF_CMD_WRITE_NE) || (c == ATATF_CMD_WRITE_MULT)) begin
      kind_of = ATATF_KIND_WRITE;
    end else begin
      kind_of = ATATF_KIND_OTHER;
    end
  endfunction : kind_of

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  assign selected = head_and_addressing_select_q[ATATF_HS_UNIT_BIT] == card_number; // RULE_04
  assign wr_ctl = reg_wr && (reg_addr == ATATF_OFS_ALT_STATUS) && reg_ctl_sel;
  assign wr_ok = reg_wr && !busy_flag_q && !soft_reset_bit_q && !wr_ctl; // RULE_25
  assign cmd_wr = wr_ok && (reg_addr == ATATF_OFS_STATUS) && selected; // RULE_13
  assign media_cmd = is_media(reg_wdata); // RULE_14 RULE_15
  assign known_cmd = media_cmd || (reg_wdata == ATATF_CMD_SET_MULT) ||
    (reg_wdata == ATATF_CMD_IDENTIFY);
  // Media commands are refused unless ready and seek done both stand.
  assign cmd_ok = known_cmd && core_ready && !core_write_fault &&
    (!media_cmd || core_seek_done); // RULE_08
  assign task_reset = soft_reset_bit_q; // RULE_17

  // ------------------------------------------------------------
  // Device control
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      soft_reset_bit_q <= 1'b0;
      interrupt_disable_bit_q <= 1'b0;
    end else if (wr_ctl) begin
      soft_reset_bit_q <= reg_wdata[ATATF_DC_SOFT_RESET_BIT_BIT]; // RULE_17
      interrupt_disable_bit_q <= reg_wdata[ATATF_DC_INTERRUPT_DISABLE_BIT_BIT]; // RULE_18
    end
  end

  // ------------------------------------------------------------
  // Parameter registers; soft reset restores them, not configuration
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      head_and_addressing_select_q <= ATATF_HEAD_SEL_RST;
      count_q <= ATATF_COUNT_RST;
      sector_q <= ATATF_SECTOR_RST;
      cyl_lo_q <= 8'h00;
      cyl_hi_q <= 8'h00;
    end else if (soft_reset_bit_q) begin
      head_and_addressing_select_q <= ATATF_HEAD_SEL_RST; // RULE_17
      count_q <= ATATF_COUNT_RST;
      sector_q <= ATATF_SECTOR_RST;
      cyl_lo_q <= 8'h00;
      cyl_hi_q <= 8'h00;
    end else if (wr_ok) begin
      if (reg_addr == ATATF_OFS_HEAD_SEL) begin
        head_and_addressing_select_q <= reg_wdata; // RULE_01 RULE_05
      end else if (reg_addr == ATATF_OFS_COUNT) begin
        count_q <= reg_wdata;
      end else if (reg_addr == ATATF_OFS_SECTOR) begin
        sector_q <= reg_wdata;
      end else if (reg_addr == ATATF_OFS_CYL_LO) begin
        cyl_lo_q <= reg_wdata;
      end else if (reg_addr == ATATF_OFS_CYL_HI) begin
        cyl_hi_q <= reg_wdata;
      end
    end
  end

  // ------------------------------------------------------------
  // Command issue
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cmd_out <= '0;
      multiple_size <= ATATF_MULT_RST;
    end else begin
      cmd_out.valid <= cmd_wr && cmd_ok && !soft_reset_bit_q;
      if (cmd_wr) begin
        cmd_out.code <= reg_wdata;
        cmd_out.kind <= kind_of(reg_wdata); // RULE_14 RULE_15
        cmd_out.lba_mode <= head_and_addressing_select_q[ATATF_HS_LBA_BIT]; // RULE_01
        cmd_out.lba <= {head_and_addressing_select_q[3:0], cyl_hi_q, cyl_lo_q, sector_q}; // RULE_02
        cmd_out.count <= (count_q == 8'h00) ? ATATF_COUNT_FULL : {1'b0, count_q}; // RULE_16
        if (reg_wdata == ATATF_CMD_SET_MULT && cmd_ok) begin
          multiple_size <= count_q; // RULE_15
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Status flags
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      busy_flag_q <= 1'b0;
      transfer_request_flag_q <= 1'b0;
      repaired_data_flag_q <= 1'b0;
      error_flag_q <= 1'b0;
      error_q <= 8'h00;
    end else if (soft_reset_bit_q) begin
      busy_flag_q <= 1'b1;
      transfer_request_flag_q <= 1'b0;
      repaired_data_flag_q <= 1'b0;
      error_flag_q <= 1'b0;
      error_q <= 8'h00;
    end else if (cmd_wr) begin
      // A new command clears leftovers; same-cycle xfer ready, repaired and fail events still set their flags, but not busy or error_q.
      busy_flag_q <= cmd_ok;
      transfer_request_flag_q <= core_xfer_ready; // RULE_09
      repaired_data_flag_q <= core_repaired;
      error_flag_q <= !cmd_ok || core_fail; // RULE_11
      error_q <= cmd_ok ? 8'h00 : (8'h01 << ATATF_ERR_ABORT_BIT); // RULE_24
    end else begin
      if (core_done || core_fail || core_xfer_ready) begin
        busy_flag_q <= 1'b0;
      end
      if (core_xfer_ready) begin
        transfer_request_flag_q <= 1'b1; // RULE_09
      end else if (core_xfer_end || core_done || core_fail) begin
        transfer_request_flag_q <= 1'b0;
      end
      if (core_repaired) begin
        repaired_data_flag_q <= 1'b1; // RULE_10
      end
      if (core_fail) begin
        error_flag_q <= 1'b1; // RULE_11
        error_q <= core_err_code;
      end
    end
  end

  always_comb begin
    status.busy_flag = busy_flag_q;
    status.unit_ready_flag = core_ready;
    status.write_fault_flag = core_write_fault; // RULE_10
    status.seek_done_flag = core_seek_done;
    status.transfer_request_flag = transfer_request_flag_q;
    status.repaired_data_flag = repaired_data_flag_q;
    status.index_flag = 1'b0; // RULE_07
    status.error_flag = error_flag_q;
  end

  // ------------------------------------------------------------
  // Interrupt; the event set wins over a clearing status read
  // ------------------------------------------------------------
  logic status_rd;
  assign status_rd = reg_rd && (reg_addr == ATATF_OFS_STATUS) && (card_index != 2'b00) &&
    level_irq_mode; // RULE_06 RULE_12
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      irq_pend_q <= 1'b0;
    end else if (soft_reset_bit_q) begin
      irq_pend_q <= 1'b0;
    end else if (core_irq) begin
      irq_pend_q <= 1'b1;
    end else if (status_rd) begin
      irq_pend_q <= 1'b0; // RULE_06
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      interrupt_request_n <= 1'b1;
    end else begin
      interrupt_request_n <= !(irq_pend_q && !interrupt_disable_bit_q && selected); // RULE_18
    end
  end

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      reg_rdata <= 8'h00;
      reg_rdata_oe <= 1'b0;
      reg_bit7_oe <= 1'b0;
    end else begin
      reg_rdata_oe <= reg_rd && selected; // RULE_04
      reg_bit7_oe <= reg_rd && selected && (reg_addr != ATATF_OFS_UNIT_READBACK); // RULE_20
      if (reg_addr == ATATF_OFS_STATUS || reg_addr == ATATF_OFS_ALT_STATUS) begin
        reg_rdata <= status; // RULE_07 RULE_12
      end else if (reg_addr == ATATF_OFS_ERROR) begin
        reg_rdata <= error_q;
      end else if (reg_addr == ATATF_OFS_COUNT) begin
        reg_rdata <= count_q;
      end else if (reg_addr == ATATF_OFS_SECTOR) begin
        reg_rdata <= sector_q;
      end else if (reg_addr == ATATF_OFS_CYL_LO) begin
        reg_rdata <= cyl_lo_q;
      end else if (reg_addr == ATATF_OFS_CYL_HI) begin
        reg_rdata <= cyl_hi_q;
      end else if (reg_addr == ATATF_OFS_HEAD_SEL) begin
        reg_rdata <= head_and_addressing_select_q;
      end else if (reg_addr == ATATF_OFS_UNIT_READBACK) begin
        reg_rdata <= {1'b0, 1'b0, ~head_and_addressing_select_q[3:0],
          head_and_addressing_select_q[ATATF_HS_UNIT_BIT] ? 2'b01 : 2'b10}; // RULE_20
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // ------------------------------------------------------------
  // Identify words
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      id_data <= 16'h0000;
    end else if (id_addr == 8'd1 || id_addr == 8'd54) begin
      id_data <= ATATF_ID_CYLINDERS; // RULE_21
    end else if (id_addr == 8'd3 || id_addr == 8'd55) begin
      id_data <= ATATF_ID_HEADS;
    end else if (id_addr == 8'd5) begin
      id_data <= ATATF_ID_BYTES_SECT;
    end else if (id_addr == 8'd6 || id_addr == 8'd56) begin
      id_data <= ATATF_ID_SECTORS;
    end else if (id_addr >= 8'd10 && id_addr <= 8'd14) begin
      id_data <= SERIAL_WORD;
    end else if (id_addr >= 8'd23 && id_addr <= 8'd25) begin
      id_data <= FIRMWARE_WORD;
    end else if (id_addr >= 8'd27 && id_addr <= 8'd31) begin
      id_data <= MODEL_WORD;
    end else if ((id_addr >= 8'd15 && id_addr <= 8'd19) || id_addr == 8'd26 ||
                 (id_addr >= 8'd32 && id_addr <= 8'd46)) begin
      id_data <= ATATF_ID_FILL;
    end else if (id_addr == 8'd47) begin
      id_data <= ATATF_ID_MULT_MAX; // RULE_23
    end else if (id_addr == 8'd49) begin
      id_data <= ATATF_ID_CAPS; // RULE_22
    end else begin
      id_data <= 16'h0000;
    end
  end
endmodule : atatf_regs
`default_nettype wire

// ---- atatf_pkg.sv ----
// Purpose: Shared constants and types for the task-file control and status block.
// Assumes: Byte-wide register port, internal 50 MHz clock.
// Notes: Offsets follow the contiguous I/O layout of the task file.
package atatf_pkg;
  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [3:0] ATATF_OFS_ERROR = 4'h1;
  localparam logic [3:0] ATATF_OFS_COUNT = 4'h2;
  localparam logic [3:0] ATATF_OFS_SECTOR = 4'h3;
  localparam logic [3:0] ATATF_OFS_CYL_LO = 4'h4;
  localparam logic [3:0] ATATF_OFS_CYL_HI = 4'h5;
  localparam logic [3:0] ATATF_OFS_HEAD_SEL = 4'h6;
  localparam logic [3:0] ATATF_OFS_STATUS = 4'h7;
  localparam logic [3:0] ATATF_OFS_ALT_STATUS = 4'he;
  localparam logic [3:0] ATATF_OFS_UNIT_READBACK = 4'hf;
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int ATATF_HS_LBA_BIT = 6;
  localparam int ATATF_HS_UNIT_BIT = 4;
  localparam int ATATF_DC_SOFT_RESET_BIT_BIT = 2;
  localparam int ATATF_DC_INTERRUPT_DISABLE_BIT_BIT = 1;
  localparam int ATATF_ERR_ABORT_BIT = 2;
  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] ATATF_HEAD_SEL_RST = 8'ha0;
  localparam logic [7:0] ATATF_COUNT_RST = 8'h01;
  localparam logic [7:0] ATATF_SECTOR_RST = 8'h01;
  localparam logic [7:0] ATATF_MULT_RST = 8'h01;
  localparam logic [8:0] ATATF_COUNT_FULL = 9'h100;
  // ------------------------------------------------------------
  // Command codes
  // ------------------------------------------------------------
  localparam logic [7:0] ATATF_CMD_READ0 = 8'h20;
  localparam logic [7:0] ATATF_CMD_READ1 = 8'h21;
  localparam logic [7:0] ATATF_CMD_WRITE0 = 8'h30;
  localparam logic [7:0] ATATF_CMD_WRITE1 = 8'h31;
  localparam logic [7:0] ATATF_CMD_WRITE_NE = 8'h38;
  localparam logic [7:0] ATATF_CMD_READ_MULT = 8'hc4;
  localparam logic [7:0] ATATF_CMD_WRITE_MULT = 8'hc5;
  localparam logic [7:0] ATATF_CMD_SET_MULT = 8'hc6;
  localparam logic [7:0] ATATF_CMD_IDENTIFY = 8'hec;
  localparam logic [7:0] ATATF_CMD_SEEK_HI = 8'h70;
  // ------------------------------------------------------------
  // Identify words
  // ------------------------------------------------------------
  localparam logic [15:0] ATATF_ID_CYLINDERS = 16'h01f3;
  localparam logic [15:0] ATATF_ID_HEADS = 16'h0004;
  localparam logic [15:0] ATATF_ID_SECTORS = 16'h0020;
  localparam logic [15:0] ATATF_ID_CAPS = 16'h0a00;
  localparam logic [15:0] ATATF_ID_MULT_MAX = 16'h0001;
  localparam logic [15:0] ATATF_ID_BYTES_SECT = 16'h0200;
  localparam logic [15:0] ATATF_ID_FILL = 16'h2020;
  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    ATATF_KIND_NONE = 2'b00,
    ATATF_KIND_READ = 2'b01,
    ATATF_KIND_WRITE = 2'b10,
    ATATF_KIND_OTHER = 2'b11
  } atatf_kind_t;
  typedef struct packed {
    logic busy_flag;
    logic unit_ready_flag;
    logic write_fault_flag;
    logic seek_done_flag;
    logic transfer_request_flag;
    logic repaired_data_flag;
    logic index_flag;
    logic error_flag;
  } atatf_status_t;
  typedef struct packed {
    logic valid;
    atatf_kind_t kind;
    logic [7:0] code;
    logic [27:0] lba;
    logic lba_mode;
    logic [8:0] count;
  } atatf_cmd_t;
endpackage : atatf_pkg

// ---- atatf_props.sv ----
// Purpose: Port-level checker for the task-file register block.
// Assumes: One ref_clk domain; reset_n low disables every check.
// Notes: Bound to every atatf_regs instance after the module.
`timescale 1ns/1ps
`default_nettype none
module atatf_props
  import atatf_pkg::*;
(
  input wire logic ref_clk, // clock
  input wire logic reset_n, // reset
  input wire logic [3:0] reg_addr, // offset
  input wire logic reg_rd, // read
  input wire logic reg_wr, // write
  input wire logic reg_ctl_sel, // ctl select
  input wire logic [7:0] reg_wdata, // wdata
  input wire logic reg_bit7_oe, // bit 7 oe
  input wire logic [1:0] card_index, // index
  input wire logic level_irq_mode, // level mode
  input wire logic core_ready, // ready
  input wire logic core_write_fault, // fault
  input wire logic core_irq, // irq event
  input wire atatf_pkg::atatf_cmd_t cmd_out, // command
  input wire logic task_reset, // soft reset
  input wire logic interrupt_request_n // irq out
);
  import atatf_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  wire logic st_rd = reg_rd && reg_addr == 4'h7 && card_index != 2'h0 && level_irq_mode;
  wire logic ctl_wr = reg_wr && reg_addr == 4'he && reg_ctl_sel;
  irq_negate_a: assert property ((st_rd && !core_irq) ##1 !core_irq |=> interrupt_request_n)
    else $error("status read left irq asserted");
  alt_keep_a: assert property (reg_rd && reg_addr == 4'he && !interrupt_request_n && !reg_wr &&
    !$past(reg_rd) && !$past(reg_wr) |=> !interrupt_request_n)
    else $error("alternate status read dropped irq");
  cmd_ready_a: assert property (cmd_out.valid |-> $past(core_ready) && !$past(core_write_fault))
    else $error("command taken while not ready");
  cmd_code_a: assert property (cmd_out.valid |-> $past(reg_wr) && $past(reg_addr) == 4'h7 &&
    cmd_out.code == $past(reg_wdata))
    else $error("command code not from command write");
  count_range_a: assert property (cmd_out.valid |-> cmd_out.count inside {[9'h001:9'h100]})
    else $error("sector count out of range");
  read_kind_a: assert property (cmd_out.valid && cmd_out.code inside {8'h20, 8'h21, 8'hc4}
    |-> cmd_out.kind == ATATF_KIND_READ)
    else $error("read code wrongly classed");
  write_kind_a: assert property (cmd_out.valid && cmd_out.code inside {8'h30, 8'h31, 8'h38, 8'hc5}
    |-> cmd_out.kind == ATATF_KIND_WRITE)
    else $error("write code wrongly classed");
  bit7_float_a: assert property (reg_rd && reg_addr == 4'hf |=> !reg_bit7_oe)
    else $error("readback bit 7 driven");
  soft_reset_a: assert property (ctl_wr |=> task_reset == $past(reg_wdata[2]))
    else $error("soft reset level wrong");
  irq_gate_a: assert property (ctl_wr && reg_wdata[1] |-> ##2 interrupt_request_n)
    else $error("disabled irq still asserted");
  cover property (cmd_out.valid);
  cover property (st_rd && !interrupt_request_n);
  cover property (reg_rd && reg_addr == 4'hf);
endmodule : atatf_props
bind atatf_regs atatf_props u_props (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_ctl_sel(reg_ctl_sel), .reg_wdata(reg_wdata),
  .reg_bit7_oe(reg_bit7_oe), .card_index(card_index), .level_irq_mode(level_irq_mode),
  .core_ready(core_ready), .core_write_fault(core_write_fault), .core_irq(core_irq),
  .cmd_out(cmd_out), .task_reset(task_reset), .interrupt_request_n(interrupt_request_n));
`default_nettype wire

// ---- atatf_host.sv ----
// Purpose: Host controller model issuing task-file register accesses.
// Assumes: One-cycle strobes launched just after a rising edge.
// Notes: Released write data shows the inverse of the last byte.
`timescale 1ns/1ps
`default_nettype none
module atatf_host (
  input wire logic ref_clk, // clock
  output logic [3:0] reg_addr, // offset
  output logic reg_rd, // read strobe
  output logic reg_wr, // write strobe
  output logic reg_ctl_sel, // ctl select
  output logic [7:0] reg_wdata // write data
);
  initial {reg_addr, reg_rd, reg_wr, reg_ctl_sel, reg_wdata} = '0;
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_ctl_sel <= (a == 4'he);
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask : wr
  task automatic ctl(input logic soft_reset_bit, input logic interrupt_disable_bit);
    wr(4'he, {4'h0, 1'b1, soft_reset_bit, interrupt_disable_bit, 1'b0});
  endtask : ctl
  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask : rd
endmodule : atatf_host
`default_nettype wire

// ---- atatf_regs_bench.sv ----
// Purpose: Self-checking bench for the task-file register block.
// Assumes: Card number 0, contiguous I/O index, level interrupts.
// Notes: Expected reads and commands are queued and popped by a monitor.
`timescale 1ns/1ps
`default_nettype none
module atatf_regs_bench;
  import atatf_pkg::*;
  logic ref_clk, reset_n, reg_rd, reg_wr, reg_ctl_sel, reg_rdata_oe, reg_bit7_oe;
  logic rdy, seek, wf, task_reset, interrupt_request_n, lb;
  logic [3:0] reg_addr, h;
  logic [5:0] ev;
  logic [1:0] idx = 2'h1;
  logic [7:0] reg_wdata, reg_rdata, err, ida, multiple_size, hi, lo, sec, cnt;
  logic [15:0] id_data;
  logic [15:0] q_rd [$];
  atatf_cmd_t cmd_out, ec, g;
  atatf_cmd_t q_cm [$];
  int n_fail = 0, n_checks = 0, seed;
  logic [7:0] codes [8] = '{8'h20, 8'h21, 8'h30, 8'h31, 8'h38, 8'hc4, 8'hc5, 8'hc6};
  atatf_kind_t kinds [8] = '{ATATF_KIND_READ, ATATF_KIND_READ, ATATF_KIND_WRITE,
    ATATF_KIND_WRITE, ATATF_KIND_WRITE, ATATF_KIND_READ, ATATF_KIND_WRITE, ATATF_KIND_OTHER};
  logic [7:0] id_a [5] = '{8'd1, 8'd3, 8'd6, 8'd47, 8'd49};
  logic [15:0] id_v [5] = '{16'h01f3, 16'h0004, 16'h0020, 16'h0001, 16'h0a00};
  atatf_regs u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_ctl_sel(reg_ctl_sel), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rdata_oe(reg_rdata_oe), .reg_bit7_oe(reg_bit7_oe), .card_index(idx),
    .level_irq_mode(1'b1), .card_number(1'b0), .core_ready(rdy), .core_seek_done(seek),
    .core_done(ev[0]), .core_fail(ev[1]), .core_err_code(err), .core_xfer_ready(ev[2]),
    .core_xfer_end(ev[3]), .core_repaired(ev[4]), .core_write_fault(wf), .core_irq(ev[5]),
    .id_addr(ida), .id_data(id_data), .cmd_out(cmd_out), .multiple_size(multiple_size),
    .task_reset(task_reset), .interrupt_request_n(interrupt_request_n));
  atatf_host u_host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_ctl_sel(reg_ctl_sel), .reg_wdata(reg_wdata));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic chk_rd(input logic [7:0] e, input logic [7:0] v);
    n_checks++;
    if (v !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, v);
    end
  endtask : chk_rd
  task automatic chk_cm(input atatf_cmd_t e, input atatf_cmd_t v);
    n_checks++;
    if (v !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, v);
    end
  endtask : chk_cm
  task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] v);
    q_rd.push_back({m, v});
    u_host.rd(a);
  endtask : rd
  task automatic issue(input logic [7:0] c, input atatf_kind_t k);
    q_cm.push_back('{1'b1, k, c, {h, hi, lo, sec}, lb, (cnt == 8'h00) ? 9'h100 : {1'b0, cnt}});
    u_host.wr(4'h7, c);
  endtask : issue
  task automatic pulse(input int b);
    @(posedge ref_clk);
    ev[b] <= 1'b1;
    @(posedge ref_clk);
    ev <= 6'h00;
  endtask : pulse
  task automatic irq_is(input logic v);
    repeat (3) @(negedge ref_clk);
    chk_rd({7'h0, v}, {7'h0, interrupt_request_n});
  endtask : irq_is
  // Results are sampled on the falling edge, well clear of launching edges.
  always @(negedge ref_clk) begin
    if (reg_rdata_oe === 1'b1) begin
      if (q_rd.size() != 0) chk_rd(q_rd[0][7:0], reg_rdata & q_rd[0][15:8]);
      else chk_rd(~reg_rdata, reg_rdata);
      if (q_rd.size() != 0) q_rd.pop_front();
    end
    if (cmd_out.valid === 1'b1) begin
      ec = (q_cm.size() != 0) ? q_cm.pop_front() : '0;
      g = cmd_out;
      if (ec.lba_mode === 1'b0) g.lba = ec.lba;
      chk_cm(ec, g);
    end
  end
  task automatic final_report;
    n_fail += q_rd.size() + q_cm.size();
    $display("checks=%0d failures=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report
  initial begin
    #400us;
    n_fail++;
    final_report();
  end
  initial begin
    seed = $urandom(32'hd039);
    {reset_n, rdy, seek, wf, ev, ida} = '0;
    err = 8'h40;
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    rdy <= 1'b1;
    seek <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rd(4'h7, 8'hff, 8'h50);
    rd(4'he, 8'hff, 8'h50);
    for (int i = 0; i < 8; i++) begin
      {h, hi, lo, sec, cnt} = 36'({$urandom, $urandom});
      if (i == 0) cnt = 8'h00;
      lb = i[0];
      u_host.wr(4'h2, cnt);
      u_host.wr(4'h3, sec);
      u_host.wr(4'h4, lo);
      u_host.wr(4'h5, hi);
      u_host.wr(4'h6, {1'b1, lb, 1'b1, 1'b0, h});
      issue(codes[i], kinds[i]);
      pulse(2);
      rd(4'h7, 8'hff, 8'h58);
      pulse(0);
      if (i == 7) chk_rd(cnt, multiple_size);
    end
    wf <= 1'b1;
    u_host.wr(4'h7, 8'h20);
    rd(4'h7, 8'hf7, 8'h71);
    rd(4'h1, 8'hff, 8'h04);
    wf <= 1'b0;
    rdy <= 1'b0;
    u_host.wr(4'h7, 8'h30);
    rd(4'h7, 8'hf7, 8'h11);
    rdy <= 1'b1;
    u_host.wr(4'h7, 8'h5a);
    rd(4'h1, 8'hff, 8'h04);
    issue(8'h20, ATATF_KIND_READ);
    pulse(1);
    rd(4'h1, 8'hff, 8'h40);
    pulse(4);
    rd(4'h7, 8'hf7, 8'h55);
    issue(8'h30, ATATF_KIND_WRITE);
    pulse(0);
    rd(4'h7, 8'hf3, 8'h50);
    u_host.wr(4'h6, {4'hf, h});
    u_host.wr(4'h7, 8'h20);
    u_host.wr(4'h6, {4'he, h});
    rd(4'hf, 8'h7f, {2'b00, ~h, 2'b10});
    u_host.ctl(1'b0, 1'b0);
    pulse(5);
    irq_is(1'b0);
    rd(4'he, 8'hf3, 8'h50);
    irq_is(1'b0);
    idx <= 2'h0;
    rd(4'h7, 8'hf3, 8'h50);
    irq_is(1'b0);
    idx <= 2'h1;
    rd(4'h7, 8'hf3, 8'h50);
    irq_is(1'b1);
    pulse(5);
    u_host.ctl(1'b0, 1'b1);
    irq_is(1'b1);
    u_host.ctl(1'b1, 1'b0);
    irq_is(1'b1);
    chk_rd(8'h01, {7'h0, task_reset});
    u_host.wr(4'h6, 8'he5);
    u_host.ctl(1'b0, 1'b0);
    pulse(0);
    rd(4'h6, 8'hff, 8'ha0);
    for (int i = 0; i < 5; i++) begin
      @(posedge ref_clk);
      ida <= id_a[i];
      repeat (2) @(negedge ref_clk);
      chk_rd(id_v[i][15:8], id_data[15:8]);
      chk_rd(id_v[i][7:0], id_data[7:0]);
    end
    repeat (4) @(posedge ref_clk);
    final_report();
  end
endmodule : atatf_regs_bench
`default_nettype wire
